// ### single_wire_uart_slave_link_bench.sv
/*
  Bench: host and device ends joined by one link interface.
  Assumes a 100 MHz mclk and a 20-cycle bit time on both ends.
*/
`timescale 1ns/1ps
module single_wire_uart_slave_link_bench;
  localparam int BIT = 20;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, cmd_ready, cmd_write, pin, rsp_valid, rsp_ok, wr_valid, rd_req, rx_error;
  logic [7:0] cmd_node, node_set, wr_count;
  logic [6:0] cmd_reg, wr_addr, rd_addr;
  logic [31:0] cmd_data, rd_data, rsp_data, wr_data;
  logic [3:0] delay_set;
  int bad_count, comparisons, n_wr, n_rd, n_err;
  swu_if link();
  swu_device #(.BIT_RESET(BIT)) swu_device_inst (.mclk(mclk), .rst_n(rst_n), .link(link),
    .node_address_setting(node_set), .address_increment_pin(pin),
    .reply_delay_setting(delay_set), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_count(wr_count), .rx_error(rx_error));
  swu_host #(.BIT_CYCLES(BIT)) swu_host_inst (.mclk(mclk), .rst_n(rst_n), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_node(cmd_node),
    .cmd_reg(cmd_reg), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_data(rsp_data));
  swu_link_sva #(.BIT(BIT), .DELAY_BITS(16)) swu_link_sva_inst (.mclk(mclk), .rst_n(rst_n),
    .line(link.line), .host_out(link.host_out), .host_oe_n(link.host_oe_n),
    .dev_out(link.dev_out), .dev_oe_n(link.dev_oe_n));
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    n_wr += (wr_valid === 1'b1);
    n_rd += (rd_req === 1'b1);
    n_err += (rx_error === 1'b1);
  end
  task give_verdict;
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task run(input logic w, input logic [7:0] node, input logic [6:0] rg, input logic [31:0] d);
    int i;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++)
    begin
      @(posedge mclk);
      #1;
    end
    if (i == 100)
    begin
      bad_count++;
      give_verdict();
    end
    cmd_write = w;
    cmd_node = node;
    cmd_reg = rg;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    // Longest case is a read left unanswered: gap, request and reply wait
    for (i = 0; i < 8000 && rsp_valid !== 1'b1; i++)
    begin
      @(posedge mclk);
      #1;
    end
    if (i == 8000)
    begin
      bad_count++;
      give_verdict();
    end
  endtask
  initial
  begin
    {cmd_valid, cmd_write, pin, cmd_node, cmd_reg, cmd_data} = '0;
    {bad_count, comparisons, n_wr, n_rd, n_err} = '0;
    node_set = 8'h21;
    delay_set = 4'h2;
    rd_data = 32'h12345678;
    repeat (10) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    run(1'b1, 8'h21, 7'h12, 32'hA5C30F81);
    check("wr_addr", 32'h00000012, {25'h0, wr_addr});
    check("wr_data", 32'hA5C30F81, wr_data);
    check("wr_count", 32'h00000001, {24'h0, wr_count});
    run(1'b0, 8'h21, 7'h33, 32'h0);
    check("rd_addr", 32'h00000033, {25'h0, rd_addr});
    check("rsp_ok", 32'h00000001, {31'h0, rsp_ok});
    check("rsp_data", 32'h12345678, rsp_data);
    check("wr_count", 32'h00000001, {24'h0, wr_count});
    run(1'b1, 8'h22, 7'h05, 32'h000000FF);
    check("writes", 32'h00000001, 32'(n_wr));
    pin = 1'b1;
    run(1'b1, 8'h22, 7'h7F, 32'hFFFFFFFF);
    check("wr_addr", 32'h0000007F, {25'h0, wr_addr});
    check("wr_count", 32'h00000002, {24'h0, wr_count});
    run(1'b0, 8'h21, 7'h01, 32'h0);
    check("rsp_ok", 32'h00000000, {31'h0, rsp_ok});
    rd_data = 32'h80000001;
    run(1'b0, 8'h22, 7'h01, 32'h0);
    check("rsp_data", 32'h80000001, rsp_data);
    check("reads", 32'h00000002, 32'(n_rd));
    check("errors", 32'h00000000, 32'(n_err));
    give_verdict();
  end
endmodule // single_wire_uart_slave_link_bench

// ### swu_device.sv
/*
  Device end of the single-wire UART register link: baud measurement,
  datagram reception, error recovery, write counter and read reply.
  Assumes the line is already synchronous to mclk; register file outside.
*/
//
// Behaviour
// - Write datagram: sync, node, access/reg, data, CRC
// - LSB first in byte, MSB byte first
// - Sync nibble 1010 opens every transmission
// - Bytes framed by low start, high stop
// - Bit time measured over sync, every datagram
// - Host keeps baud between 9000 and fclk/16
// - Node address is setting plus increment pin
// - Over 63 bit gap resets reception
// - Host idles 12 bits after reset
// - Short idle pulse triggers 12-bit idle timeout
// - CRC or framing error: discard and recover
// - Host avoids abrupt baud drop below 15%
// - 8-bit counter counts accepted writes only
// - CRC8 0x07, zero init, own node only
// - Reply waits setting times eight bit times
// - Reply carries all-ones node address
// - Driver released four bits after reply
`timescale 1ns/1ps
module swu_device #(
  parameter int BIT_RESET = swu_pkg::BIT_DEFAULT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Shared line
  swu_if.dev link,
  // Addressing and reply timing
  input wire logic [7:0] node_address_setting,
  input wire logic address_increment_pin,
  input wire logic [3:0] reply_delay_setting,
  // Register access
  output logic wr_valid,
  output logic [6:0] wr_addr,
  output logic [31:0] wr_data,
  output logic rd_req,
  output logic [6:0] rd_addr,
  input wire logic [31:0] rd_data,
  // Status
  output logic [7:0] wr_count,
  output logic rx_error
);
  localparam int BW = swu_pkg::BIT_W;
  localparam int GW = swu_pkg::GAP_W;

  swu_pkg::dev_state_t state_ff;
  logic line_prev_ff;
  logic [GW-1:0] cnt_ff;
  logic [GW-1:0] gap_ff;
  logic [BW-1:0] tmr_ff;
  logic [BW-1:0] bit_ff;
  logic [BW-1:0] good_ff;
  logic [3:0] bidx_ff;
  logic [3:0] nbyte_ff;
  logic [7:0] byte_ff;
  logic [1:0] falls_ff;
  logic [7:0] crc_ff;
  logic [7:0] node_ff;
  logic wr_ff;
  logic [6:0] reg_ff;
  logic [31:0] dg_ff;
  logic [47:0] txdg_ff;
  logic [7:0] tx_byte_ff;
  logic tx_go_ff;
  logic tx_done;
  logic tx_line;
  logic fall;
  logic rise;
  logic [7:0] my_node;
  logic [3:0] last_byte;
  logic [7:0] crc_tx;
  logic [GW-1:0] gap_lim;
  logic [GW-1:0] idle_lim;
  logic [GW-1:0] delay_lim;
  logic [GW-1:0] tail_lim;

  assign fall = line_prev_ff & ~link.line;
  assign rise = ~line_prev_ff & link.line;
  assign my_node = node_address_setting + {7'h00, address_increment_pin};
  assign last_byte = wr_ff ? swu_pkg::LAST_WR : swu_pkg::LAST_RD;
  assign crc_tx = swu_pkg::crc8_byte(crc_ff, tx_byte_ff);
  // Timeouts use the last good bit time, so an abrupt baud drop can trip the gap timeout
  assign gap_lim = GW'(good_ff) * swu_pkg::GAP_BITS;
  assign idle_lim = GW'(good_ff) * swu_pkg::IDLE_BITS;
  assign delay_lim = GW'(bit_ff) * swu_pkg::DELAY_UNIT * GW'(reply_delay_setting);
  assign tail_lim = GW'(bit_ff) * swu_pkg::TAIL_BITS;

  // ---------------------------------------------------------------
  // Line driver
  // ---------------------------------------------------------------
  assign link.dev_out = tx_line;
  assign link.dev_oe_n = !(state_ff == swu_pkg::D_TX || state_ff == swu_pkg::D_TAIL);

  swu_tx_byte #(.BIT_W(BW)) u_tx (
    .mclk(mclk),
    .rst_n(rst_n),
    .go(tx_go_ff),
    .byte_in(tx_byte_ff),
    .bit_cycles(bit_ff),
    .line_out(tx_line),
    .busy(),
    .done(tx_done)
  );

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      line_prev_ff <= 1'b1;
    else
      line_prev_ff <= link.line;
  end

  // ---------------------------------------------------------------
  // Write counter
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      wr_count <= 8'h00;
    else if (wr_valid)
      wr_count <= wr_count + 8'h01;
  end

  // ---------------------------------------------------------------
  // Receive, recover and reply sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_ff <= swu_pkg::D_IDLE;
      cnt_ff <= '0;
      gap_ff <= '0;
      tmr_ff <= '0;
      bit_ff <= BW'(BIT_RESET);
      good_ff <= BW'(BIT_RESET);
      bidx_ff <= 4'h0;
      nbyte_ff <= 4'h0;
      byte_ff <= 8'h00;
      falls_ff <= 2'h0;
      crc_ff <= swu_pkg::CRC_INIT;
      node_ff <= 8'h00;
      wr_ff <= 1'b0;
      reg_ff <= 7'h00;
      dg_ff <= 32'h0000_0000;
      txdg_ff <= '0;
      tx_byte_ff <= 8'h00;
      tx_go_ff <= 1'b0;
      wr_valid <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 32'h0000_0000;
      rd_req <= 1'b0;
      rd_addr <= 7'h00;
      rx_error <= 1'b0;
    end
    else
    begin
      tx_go_ff <= 1'b0;
      wr_valid <= 1'b0;
      rd_req <= 1'b0;
      rx_error <= 1'b0;
      case (state_ff)
        swu_pkg::D_IDLE:
        begin
          if (fall)
          begin
            state_ff <= swu_pkg::D_SYNC;
            cnt_ff <= '0;
            gap_ff <= '0;
            falls_ff <= 2'h0;
            nbyte_ff <= 4'h0;
            crc_ff <= swu_pkg::CRC_INIT;
          end
        end
        swu_pkg::D_SYNC:
        begin
          cnt_ff <= cnt_ff + 1'b1;
          gap_ff <= gap_ff + 1'b1;
          if ((rise && falls_ff == 2'h0 && cnt_ff < GW'(swu_pkg::GLITCH_CYC))
              || cnt_ff > gap_lim)
          begin
            state_ff <= swu_pkg::D_RECOVER;
            rx_error <= 1'b1;
            cnt_ff <= '0;
          end
          else if (fall && falls_ff == swu_pkg::SYNC_FALLS)
          begin
            // Start to bit-3 edge spans four bit times
            bit_ff <= BW'((cnt_ff + 1'b1) >> swu_pkg::SYNC_SPAN_LOG2);
            tmr_ff <= BW'((cnt_ff + 1'b1) >> (swu_pkg::SYNC_SPAN_LOG2 + 1));
            bidx_ff <= swu_pkg::IDX_SYNC_RESUME;
            byte_ff <= {swu_pkg::SYNC_HEAD, 5'h00};
            state_ff <= swu_pkg::D_BITS;
          end
          else if (fall)
          begin
            falls_ff <= falls_ff + 2'h1;
          end
        end
        swu_pkg::D_BITS:
        begin
          gap_ff <= gap_ff + 1'b1;
          if (tmr_ff != '0)
          begin
            tmr_ff <= tmr_ff - 1'b1;
          end
          else
          begin
            tmr_ff <= bit_ff - 1'b1;
            bidx_ff <= bidx_ff + 1'b1;
            if (bidx_ff == swu_pkg::IDX_START && link.line)
            begin
              state_ff <= swu_pkg::D_RECOVER;
              rx_error <= 1'b1;
              cnt_ff <= '0;
            end
            else if (bidx_ff != swu_pkg::IDX_START && bidx_ff != swu_pkg::IDX_STOP)
            begin
              byte_ff <= {link.line, byte_ff[7:1]};
            end
            else if (bidx_ff == swu_pkg::IDX_STOP && !link.line)
            begin
              state_ff <= swu_pkg::D_RECOVER;
              rx_error <= 1'b1;
              cnt_ff <= '0;
            end
            else if (bidx_ff == swu_pkg::IDX_STOP)
            begin
              nbyte_ff <= nbyte_ff + 1'b1;
              dg_ff <= {dg_ff[23:0], byte_ff};
              state_ff <= swu_pkg::D_WAIT;
              if (nbyte_ff == swu_pkg::NODE_BYTE)
                node_ff <= byte_ff;
              // Register byte is shifted out of dg_ff by the data bytes, so keep it
              if (nbyte_ff == swu_pkg::REG_BYTE)
              begin
                wr_ff <= byte_ff[swu_pkg::ACC_BIT];
                reg_ff <= byte_ff[6:0];
              end
              if (nbyte_ff <= swu_pkg::REG_BYTE || nbyte_ff != last_byte)
              begin
                crc_ff <= swu_pkg::crc8_byte(crc_ff, byte_ff);
              end
              else if (byte_ff != crc_ff)
              begin
                state_ff <= swu_pkg::D_RECOVER;
                rx_error <= 1'b1;
                cnt_ff <= '0;
              end
              else
              begin
                good_ff <= bit_ff;
                cnt_ff <= '0;
                state_ff <= swu_pkg::D_IDLE;
                if (node_ff == my_node && my_node != swu_pkg::HOST_NODE)
                begin
                  if (wr_ff)
                  begin
                    wr_valid <= 1'b1;
                    wr_data <= dg_ff;
                    wr_addr <= reg_ff;
                  end
                  else
                  begin
                    rd_req <= 1'b1;
                    rd_addr <= reg_ff;
                    state_ff <= swu_pkg::D_DELAY;
                  end
                end
              end
            end
          end
        end
        swu_pkg::D_WAIT:
        begin
          gap_ff <= gap_ff + 1'b1;
          if (gap_ff > gap_lim)
          begin
            state_ff <= swu_pkg::D_RECOVER;
            rx_error <= 1'b1;
            cnt_ff <= '0;
          end
          else if (fall)
          begin
            gap_ff <= '0;
            tmr_ff <= bit_ff >> 1;
            bidx_ff <= swu_pkg::IDX_START;
            state_ff <= swu_pkg::D_BITS;
          end
        end
        swu_pkg::D_RECOVER:
        begin
          // Any low restarts the idle wait
          cnt_ff <= link.line ? cnt_ff + 1'b1 : '0;
          if (link.line && cnt_ff >= idle_lim)
            state_ff <= swu_pkg::D_IDLE;
        end
        swu_pkg::D_DELAY:
        begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff >= delay_lim)
          begin
            // Data sampled once so the reply CRC always matches its payload
            txdg_ff <= {swu_pkg::HOST_NODE, 1'b0, rd_addr, rd_data};
            tx_byte_ff <= swu_pkg::SYNC_BYTE;
            tx_go_ff <= 1'b1;
            crc_ff <= swu_pkg::CRC_INIT;
            nbyte_ff <= 4'h0;
            state_ff <= swu_pkg::D_TX;
          end
        end
        swu_pkg::D_TX:
        begin
          if (tx_done)
          begin
            crc_ff <= crc_tx;
            nbyte_ff <= nbyte_ff + 1'b1;
            txdg_ff <= {txdg_ff[39:0], 8'h00};
            if (nbyte_ff == swu_pkg::LAST_WR)
            begin
              cnt_ff <= '0;
              state_ff <= swu_pkg::D_TAIL;
            end
            else
            begin
              tx_byte_ff <= (nbyte_ff == swu_pkg::LAST_WR - 4'h1) ? crc_tx : txdg_ff[47:40];
              tx_go_ff <= 1'b1;
            end
          end
        end
        swu_pkg::D_TAIL:
        begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff >= tail_lim)
            state_ff <= swu_pkg::D_IDLE;
        end
        default:
        begin
          state_ff <= swu_pkg::D_IDLE;
        end
      endcase
    end
  end
endmodule // swu_device

// ### swu_host.sv
/*
  Host end of the single-wire UART register link: sends write and read
  datagrams at a fixed baud rate and collects read replies.
  Assumes one command at a time, taken while cmd_ready is high.
*/
`timescale 1ns/1ps
module swu_host #(
  parameter int BIT_CYCLES = swu_pkg::BIT_DEFAULT,
  parameter int REPLY_WAIT_BITS = swu_pkg::REPLY_WAIT_DEFAULT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Shared line
  swu_if.host link,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_node,
  input wire logic [6:0] cmd_reg,
  input wire logic [31:0] cmd_data,
  // Response
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [31:0] rsp_data
);
  localparam int BW = swu_pkg::BIT_W;
  localparam int GW = swu_pkg::GAP_W;
  localparam logic [BW-1:0] BIT_C = BW'(BIT_CYCLES);
  localparam logic [GW-1:0] IDLE_C = GW'(BIT_CYCLES) * swu_pkg::IDLE_BITS;
  localparam logic [GW-1:0] WAIT_C = GW'(BIT_CYCLES * REPLY_WAIT_BITS);

  swu_pkg::host_state_t state_ff;
  logic line_prev_ff;
  logic [GW-1:0] cnt_ff;
  logic [BW-1:0] tmr_ff;
  logic [3:0] bidx_ff;
  logic [3:0] nbyte_ff;
  logic [3:0] last_ff;
  logic wr_ff;
  logic [7:0] byte_ff;
  logic [7:0] crc_ff;
  logic hdr_ok_ff;
  logic [47:0] txdg_ff;
  logic [7:0] tx_byte_ff;
  logic tx_go_ff;
  logic tx_done;
  logic tx_line;
  logic [7:0] crc_tx;

  assign cmd_ready = (state_ff == swu_pkg::H_IDLE);
  assign crc_tx = swu_pkg::crc8_byte(crc_ff, tx_byte_ff);
  assign link.host_out = tx_line;
  assign link.host_oe_n = (state_ff != swu_pkg::H_SEND);

  swu_tx_byte #(.BIT_W(BW)) u_tx (
    .mclk(mclk),
    .rst_n(rst_n),
    .go(tx_go_ff),
    .byte_in(tx_byte_ff),
    .bit_cycles(BIT_C),
    .line_out(tx_line),
    .busy(),
    .done(tx_done)
  );

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      line_prev_ff <= 1'b1;
    else
      line_prev_ff <= link.line;
  end

  // ---------------------------------------------------------------
  // Command sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_ff <= swu_pkg::H_IDLE;
      cnt_ff <= '0;
      tmr_ff <= '0;
      bidx_ff <= 4'h0;
      nbyte_ff <= 4'h0;
      last_ff <= 4'h0;
      wr_ff <= 1'b0;
      byte_ff <= 8'h00;
      crc_ff <= swu_pkg::CRC_INIT;
      txdg_ff <= '0;
      hdr_ok_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
      tx_go_ff <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_ok <= 1'b0;
      rsp_data <= 32'h0000_0000;
    end
    else
    begin
      tx_go_ff <= 1'b0;
      rsp_valid <= 1'b0;
      case (state_ff)
        swu_pkg::H_IDLE:
        begin
          if (cmd_valid)
          begin
            txdg_ff <= {cmd_node, cmd_write, cmd_reg, cmd_data};
            wr_ff <= cmd_write;
            last_ff <= cmd_write ? swu_pkg::LAST_WR : swu_pkg::LAST_RD;
            tx_byte_ff <= swu_pkg::SYNC_BYTE;
            crc_ff <= swu_pkg::CRC_INIT;
            nbyte_ff <= 4'h0;
            cnt_ff <= '0;
            state_ff <= swu_pkg::H_GAP;
          end
        end
        swu_pkg::H_GAP:
        begin
          // Idle before every datagram also covers recovery after errors
          cnt_ff <= link.line ? cnt_ff + 1'b1 : '0;
          if (link.line && cnt_ff >= IDLE_C)
          begin
            tx_go_ff <= 1'b1;
            state_ff <= swu_pkg::H_SEND;
          end
        end
        swu_pkg::H_SEND:
        begin
          if (tx_done)
          begin
            crc_ff <= crc_tx;
            nbyte_ff <= nbyte_ff + 1'b1;
            txdg_ff <= {txdg_ff[39:0], 8'h00};
            if (nbyte_ff == last_ff)
            begin
              cnt_ff <= '0;
              nbyte_ff <= 4'h0;
              crc_ff <= swu_pkg::CRC_INIT;
              rsp_valid <= wr_ff;
              rsp_ok <= wr_ff;
              state_ff <= wr_ff ? swu_pkg::H_IDLE : swu_pkg::H_WAIT;
            end
            else
            begin
              tx_byte_ff <= (nbyte_ff == last_ff - 4'h1) ? crc_tx : txdg_ff[47:40];
              tx_go_ff <= 1'b1;
            end
          end
        end
        swu_pkg::H_WAIT:
        begin
          cnt_ff <= cnt_ff + 1'b1;
          if (line_prev_ff && !link.line)
          begin
            tmr_ff <= BIT_C >> 1;
            bidx_ff <= swu_pkg::IDX_START;
            cnt_ff <= '0;
            state_ff <= swu_pkg::H_RX;
          end
          else if (cnt_ff >= WAIT_C)
          begin
            rsp_valid <= 1'b1;
            rsp_ok <= 1'b0;
            state_ff <= swu_pkg::H_IDLE;
          end
        end
        swu_pkg::H_RX:
        begin
          if (tmr_ff != '0)
          begin
            tmr_ff <= tmr_ff - 1'b1;
          end
          else
          begin
            tmr_ff <= BIT_C - 1'b1;
            bidx_ff <= bidx_ff + 1'b1;
            if (bidx_ff != swu_pkg::IDX_START && bidx_ff != swu_pkg::IDX_STOP)
              byte_ff <= {link.line, byte_ff[7:1]};
            if (bidx_ff == swu_pkg::IDX_STOP)
            begin
              nbyte_ff <= nbyte_ff + 1'b1;
              state_ff <= swu_pkg::H_WAIT;
              if (nbyte_ff != swu_pkg::LAST_WR)
              begin
                crc_ff <= swu_pkg::crc8_byte(crc_ff, byte_ff);
                rsp_data <= {rsp_data[23:0], byte_ff};
                if (nbyte_ff == swu_pkg::NODE_BYTE)
                  hdr_ok_ff <= (byte_ff == swu_pkg::HOST_NODE);
              end
              else
              begin
                rsp_valid <= 1'b1;
                rsp_ok <= (byte_ff == crc_ff) && link.line && hdr_ok_ff;
                state_ff <= swu_pkg::H_IDLE;
              end
            end
          end
        end
        default:
        begin
          state_ff <= swu_pkg::H_IDLE;
        end
      endcase
    end
  end
endmodule // swu_host

// ### swu_if.sv
/*
  Shared single data line between host and device.
  Assumes a pull-up: a released end reads high.
*/
`timescale 1ns/1ps
interface swu_if;
  logic line;
  logic host_out;
  logic host_oe_n;
  logic dev_out;
  logic dev_oe_n;

  assign line = (host_oe_n | host_out) & (dev_oe_n | dev_out);

  modport dev (input line, output dev_out, output dev_oe_n);
  modport host (input line, output host_out, output host_oe_n);
endinterface

// ### swu_link_sva.sv
/*
  Checks of the shared line between the host and device ends.
  Assumes both ends run BIT cycles per bit and a reply delay of DELAY_BITS.
*/
`timescale 1ns/1ps
module swu_link_sva #(
  parameter int BIT = 20,
  parameter int DELAY_BITS = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Line and drivers
  input wire logic line,
  input wire logic host_out,
  input wire logic host_oe_n,
  input wire logic dev_out,
  input wire logic dev_oe_n
);
  localparam int HALF = BIT / 2;
  // Run lengths in cycles; no test idles long enough to wrap them
  logic [15:0] hi_ff, lo_ff, drv_ff, rel_ff;
  always_ff @(posedge mclk)
  begin
    hi_ff <= (rst_n && line) ? hi_ff + 16'h0001 : 16'h0000;
    lo_ff <= (rst_n && !line) ? lo_ff + 16'h0001 : 16'h0000;
    drv_ff <= (rst_n && !dev_oe_n) ? drv_ff + 16'h0001 : 16'h0000;
    // Counted from host release: line-high runs depend on the data bits
    rel_ff <= (rst_n && host_oe_n) ? rel_ff + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_reset_released:
    assert property ($rose(rst_n) |-> dev_oe_n && host_oe_n) else $error("driver on at reset");
  a_no_contend:
    assert property (!dev_oe_n |-> host_oe_n) else $error("both ends drive");
  a_host_gap:
    assert property ($fell(host_oe_n) |-> hi_ff >= 16'(12 * BIT)) else $error("host gap short");
  a_sync_lead:
    assert property ($fell(line) && hi_ff >= 16'(12 * BIT) |->
      ##HALF !line ##BIT line ##BIT !line ##BIT line ##BIT !line) else $error("bad sync");
  a_reply_delay:
    assert property ($fell(dev_oe_n) |-> rel_ff >= 16'((DELAY_BITS - 1) * BIT)
      && rel_ff <= 16'(DELAY_BITS * BIT)) else $error("reply delay wrong");
  a_tail_release:
    assert property ($rose(dev_oe_n) |-> drv_ff >= 16'(84 * BIT)
      && drv_ff <= 16'(85 * BIT)) else $error("tail wrong");
  a_drive_bound:
    assert property (drv_ff <= 16'(85 * BIT)) else $error("device drives too long");
  a_stop_bits:
    assert property (lo_ff <= 16'(9 * BIT + 4)) else $error("no stop bit");
endmodule // swu_link_sva

// ### swu_pkg.sv
/*
  Shared constants, state types and the CRC step of the single-wire UART link.
  Assumes one 100 MHz system clock on both ends of the link.
*/
package swu_pkg;
  // ---------------------------------------------------------------
  // Widths and clock
  // ---------------------------------------------------------------
  localparam int BIT_W = 16;
  localparam int GAP_W = 24;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_DEFAULT = 115200;
  localparam int BIT_DEFAULT = CLK_HZ / BAUD_DEFAULT;
  localparam int REPLY_WAIT_DEFAULT = 160;
  // ---------------------------------------------------------------
  // Datagram layout
  // ---------------------------------------------------------------
  localparam logic [7:0] SYNC_BYTE = 8'h05;
  localparam logic [2:0] SYNC_HEAD = 3'h5;
  localparam logic [7:0] HOST_NODE = 8'hFF;
  localparam int ACC_BIT = 7;
  localparam logic [3:0] NODE_BYTE = 4'h1;
  localparam logic [3:0] REG_BYTE = 4'h2;
  localparam logic [3:0] LAST_RD = 4'h3;
  localparam logic [3:0] LAST_WR = 4'h7;
  localparam logic [3:0] IDX_START = 4'h0;
  localparam logic [3:0] IDX_SYNC_RESUME = 4'h4;
  localparam logic [3:0] IDX_STOP = 4'h9;
  localparam logic [1:0] SYNC_FALLS = 2'h1;
  localparam int SYNC_SPAN_LOG2 = 2;
  // ---------------------------------------------------------------
  // Timing in bit times or clock cycles
  // ---------------------------------------------------------------
  localparam logic [GAP_W-1:0] GAP_BITS = 24'h00003F;
  localparam logic [GAP_W-1:0] IDLE_BITS = 24'h00000C;
  localparam logic [GAP_W-1:0] TAIL_BITS = 24'h000004;
  localparam logic [GAP_W-1:0] DELAY_UNIT = 24'h000008;
  localparam logic [BIT_W-1:0] GLITCH_CYC = 16'h0010;
  // ---------------------------------------------------------------
  // CRC
  // ---------------------------------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  typedef enum logic [3:0] {
    D_IDLE, D_SYNC, D_BITS, D_WAIT, D_RECOVER, D_DELAY, D_TX, D_TAIL
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE, H_GAP, H_SEND, H_WAIT, H_RX
  } host_state_t;

  // Byte fed LSB first, as it travels on the line
  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction
endpackage

// ### swu_tx_byte.sv
/*
  One UART frame sender: start bit, eight bits LSB first, stop bit.
  Assumes go is only raised while busy is low.
*/
`timescale 1ns/1ps
module swu_tx_byte #(
  parameter int BIT_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Request
  input wire logic go,
  input wire logic [7:0] byte_in,
  input wire logic [BIT_W-1:0] bit_cycles,
  // Line and status
  output logic line_out,
  output logic busy,
  output logic done
);
  logic [9:0] sh_ff;
  logic [3:0] idx_ff;
  logic [BIT_W-1:0] tmr_ff;
  logic busy_ff;

  assign line_out = sh_ff[0];
  assign busy = busy_ff;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sh_ff <= 10'h3FF;
      idx_ff <= 4'h0;
      tmr_ff <= '0;
      busy_ff <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (go && !busy_ff)
      begin
        sh_ff <= {1'b1, byte_in, 1'b0};
        idx_ff <= swu_pkg::IDX_START;
        tmr_ff <= bit_cycles - 1'b1;
        busy_ff <= 1'b1;
      end
      else if (busy_ff)
      begin
        if (tmr_ff == '0)
        begin
          tmr_ff <= bit_cycles - 1'b1;
          sh_ff <= {1'b1, sh_ff[9:1]};
          if (idx_ff == swu_pkg::IDX_STOP)
          begin
            busy_ff <= 1'b0;
            done <= 1'b1;
          end
          else
          begin
            idx_ff <= idx_ff + 1'b1;
          end
        end
        else
        begin
          tmr_ff <= tmr_ff - 1'b1;
        end
      end
    end
  end
endmodule // swu_tx_byte
